// ===== logic/smc_pkg.sv
// constants and carrier types for the supply margining channel control
// ==========================================================
// Functional notes
// RULE1 - Each monitored input flags an undervoltage fault when its conversion result is greater than its low limit.
// RULE2 - Each low limit is a 15-bit two's complement value in bits 14..0, with bit 15 reading zero.
// RULE3 - A low limit of the most negative code (4000h) switches undervoltage detection off for that input.
// RULE4 - While servo is active, the channel's DAC code is stepped so its conversion result approaches the target code.
// RULE5 - Bit 15 of a servo register enables servo for its channel and is zero after reset.
// RULE6 - DAC control bits 7..0 hold the 8-bit DAC code and bits 15..12 always read zero.
// RULE7 - Setting enable with connect low runs a soft connect that steps one LSB at a time until the comparator trips, then attaches.
// RULE8 - Setting enable with connect high attaches the buffer at once, and with enable clear the output is tri-stated.
// RULE9 - The connect bit reads one only once the output is enabled and attached, and zero otherwise and after reset.
// RULE10 - The host sets polarity one for non-inverting feedback, and the device steps in the direction it selects.
// RULE11 - With repeat clear servo stops once the result is stable and equal to the target, with repeat set it runs on.
// RULE12 - A soft connect ignores the written code and starts from midscale 80h.
// RULE13 - A soft connect that reaches code 00h or FFh untripped is abandoned with a DAC fault and connect left low.
// RULE14 - When both channels want a soft connect, channel zero is served first.
// RULE15 - Servo moves the DAC code by at most one LSB per new result of its channel and never past 00h or FFh.
// RULE16 - A written connect bit is taken as the connect mode only while enable is being set; otherwise the device owns it.
package smc_pkg;

   // ==========================================================
   // command register indices
   localparam logic [3:0] IDX_LOGIC_SUPPLY_LOW_LIMIT = 4'h0;
   localparam logic [3:0] IDX_INPUT_12V_LOW_LIMIT = 4'h1;
   localparam logic [3:0] IDX_CHAN0_PRIMARY_LOW_LIMIT = 4'h2;
   localparam logic [3:0] IDX_CHAN0_SECONDARY_LOW_LIMIT = 4'h3;
   localparam logic [3:0] IDX_CHAN1_PRIMARY_LOW_LIMIT = 4'h4;
   localparam logic [3:0] IDX_CHAN1_SECONDARY_LOW_LIMIT = 4'h5;
   localparam logic [3:0] IDX_CHAN0_SERVO_TARGET = 4'h6;
   localparam logic [3:0] IDX_CHAN1_SERVO_TARGET = 4'h7;
   localparam logic [3:0] IDX_CHAN0_CURRENT_DAC_CTRL = 4'h8;
   localparam logic [3:0] IDX_CHAN1_CURRENT_DAC_CTRL = 4'h9;

   // ==========================================================
   // field positions
   localparam int SERVO_EN_BIT = 15;
   localparam int DAC_EN_BIT = 8;
   localparam int DAC_CON_BIT = 9;
   localparam int DAC_POL_BIT = 10;
   localparam int DAC_RPT_BIT = 11;

   // ==========================================================
   // values and counts
   localparam int NUM_INPUTS = 6;
   localparam logic [2:0] ADC_SEL_CHAN0 = 3'h2;
   localparam logic [2:0] ADC_SEL_CHAN1 = 3'h4;
   localparam logic [14:0] UV_DISABLE_CODE = 15'h4000;
   localparam logic [14:0] LIMIT_RESET = 15'h0000;
   localparam logic [7:0] DAC_MIDSCALE = 8'h80;
   localparam logic [7:0] DAC_CODE_MIN = 8'h00;
   localparam logic [7:0] DAC_CODE_MAX = 8'hFF;
   localparam logic [7:0] DAC_CODE_RESET = 8'h00;
   localparam int CLK_PERIOD_NS = 50;
   localparam int SOFT_STEP_NS = 10000;
   localparam int SOFT_STEP_CYCLES_I = (SOFT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] SOFT_STEP_CYCLES = SOFT_STEP_CYCLES_I[7:0];

   // ==========================================================
   // carriers
   typedef enum logic [0:0]
   {
      SMC_SC_IDLE = 1'b0,
      SMC_SC_STEP = 1'b1
   } smc_sc_state_t;

   typedef struct packed
   {
      logic [7:0] code;
      logic en;
      logic con;
      logic pol;
      logic rpt;
      logic flt;
      logic busy;
   } smc_dac_t;

   typedef struct packed
   {
      logic wr_en;
      logic rd_en;
      logic [3:0] idx;
      logic [15:0] wdata;
   } smc_cmd_t;

   typedef struct packed
   {
      logic valid;
      logic [2:0] sel;
      logic [14:0] result;
   } smc_adc_t;

endpackage

// ===== logic/smc_channel_ctrl.sv
// low limit check, voltage servo and current DAC connect control for two channels
`timescale 1ns/10ps
`default_nettype none

module smc_channel_ctrl
   import smc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // command register port
   input wire smc_cmd_t cmd,
   output logic [15:0] cmd_rdata,
   // conversion results
   input wire smc_adc_t adc,
   // soft connect comparators, high while current_dac_pin is below margin_output_pin
   input wire logic [1:0] soft_cmp,
   // analog controls
   output logic [1:0][7:0] dac_code,
   output logic [1:0] margin_output_en,
   output logic [1:0] buffer_attach,
   // status
   output logic [1:0] dac_fault,
   output logic [NUM_INPUTS-1:0] uv_fault
);

   // ==========================================================
   // state
   typedef struct packed
   {
      logic [15:0] rdata;
      logic [NUM_INPUTS-1:0][14:0] uv_lim;
      logic [NUM_INPUTS-1:0] uv_flt;
      logic [1:0][14:0] tgt;
      logic [1:0] servo_en;
      smc_dac_t [1:0] dac;
      logic [1:0][14:0] last;
      logic [1:0] last_ok;
      smc_sc_state_t sc;
      logic sc_ch;
      logic sc_cmp0;
      logic sc_prime;
      logic [7:0] div;
      logic [1:0] cmp_s1;
      logic [1:0] cmp_s2;
   } smc_state_t;

   smc_state_t s_q;
   smc_state_t s_d;

   // ==========================================================
   // helpers
   function automatic logic signed_gt(input logic [14:0] a, input logic [14:0] b);
      signed_gt = $signed(a) > $signed(b);
   endfunction

   function automatic logic [7:0] step_code(input logic [7:0] c, input logic up);
      logic [7:0] r;
      r = c;
      if (up && c != DAC_CODE_MAX)
         r = c + 8'h01;
      else if (!up && c != DAC_CODE_MIN)
         r = c - 8'h01;
      step_code = r;
   endfunction

   function automatic logic [15:0] dac_word(input smc_dac_t d);
      dac_word = {4'h0, d.rpt, d.pol, d.con, d.en, d.code}; // RULE6
   endfunction

   // captured comparator against polarity picks the walk direction
   function automatic logic walk_up(input logic cmp0, input logic pol);
      walk_up = cmp0 == pol; // RULE10
   endfunction

   function automatic logic servo_up(input logic [14:0] tgt, input logic [14:0] res,
      input logic pol);
      servo_up = signed_gt(tgt, res) ? pol : !pol; // RULE10
   endfunction

   // the most negative limit code switches the compare off
   function automatic logic uv_trip(input logic [14:0] res, input logic [14:0] lim);
      if (lim == UV_DISABLE_CODE) // RULE3
         uv_trip = 1'b0;
      else
         uv_trip = signed_gt(res, lim); // RULE1
   endfunction

   // ==========================================================
   // register decode, shared by the read and write paths
   function automatic logic is_limit(input logic [3:0] i);
      is_limit = i <= IDX_CHAN1_SECONDARY_LOW_LIMIT;
   endfunction

   function automatic logic is_servo(input logic [3:0] i);
      is_servo = i == IDX_CHAN0_SERVO_TARGET || i == IDX_CHAN1_SERVO_TARGET;
   endfunction

   function automatic logic is_dac(input logic [3:0] i);
      is_dac = i == IDX_CHAN0_CURRENT_DAC_CTRL || i == IDX_CHAN1_CURRENT_DAC_CTRL;
   endfunction

   function automatic logic chan_of(input logic [3:0] i, input logic [3:0] base);
      chan_of = i[0] ^ base[0];
   endfunction

   // ==========================================================
   // next state
   always_comb
   begin
      logic [1:0] sel_ch;
      logic cur;
      logic tick;
      logic ch_sel;
      logic rd_ch;
      logic [14:0] res;
      smc_dac_t w;
      s_d = s_q;
      sel_ch = 2'b00;
      cur = 1'b0;
      tick = 1'b0;
      ch_sel = 1'b0;
      rd_ch = 1'b0;
      res = adc.result;
      w = '0;

      // pin synchroniser
      s_d.cmp_s1 = soft_cmp;
      s_d.cmp_s2 = s_q.cmp_s1;

      // step-rate divider, only runs while a soft connect is stepping
      // the first step comes a full period after the start, never early
      if (s_q.sc == SMC_SC_STEP)
      begin
         if (s_q.div == SOFT_STEP_CYCLES - 8'h01)
         begin
            s_d.div = 8'h00;
            tick = 1'b1;
         end
         else
            s_d.div = s_q.div + 8'h01;
      end
      else
         s_d.div = 8'h00;

      // register reads, answered one cycle after the strobe
      if (cmd.rd_en)
      begin
         s_d.rdata = 16'h0000;
         if (is_limit(cmd.idx))
            s_d.rdata = {1'b0, s_q.uv_lim[cmd.idx[2:0]]}; // RULE2
         else if (is_servo(cmd.idx))
         begin
            rd_ch = chan_of(cmd.idx, IDX_CHAN0_SERVO_TARGET);
            s_d.rdata = {s_q.servo_en[rd_ch], s_q.tgt[rd_ch]}; // RULE5
         end
         else if (is_dac(cmd.idx))
            s_d.rdata = dac_word(s_q.dac[chan_of(cmd.idx, IDX_CHAN0_CURRENT_DAC_CTRL)]);
      end

      // register writes
      if (cmd.wr_en)
      begin
         if (is_limit(cmd.idx))
            s_d.uv_lim[cmd.idx[2:0]] = cmd.wdata[14:0]; // RULE2
         else if (is_servo(cmd.idx))
         begin
            ch_sel = chan_of(cmd.idx, IDX_CHAN0_SERVO_TARGET);
            s_d.tgt[ch_sel] = cmd.wdata[14:0];
            s_d.servo_en[ch_sel] = cmd.wdata[SERVO_EN_BIT]; // RULE5
            // a new target restarts the stable count
            s_d.last_ok[ch_sel] = 1'b0;
         end
         else if (is_dac(cmd.idx))
         begin
            ch_sel = chan_of(cmd.idx, IDX_CHAN0_CURRENT_DAC_CTRL);
            w = s_q.dac[ch_sel];
            if (!cmd.wdata[DAC_EN_BIT])
            begin
               // disable: tri-state, detach, drop any pending or failed connect
               w.en = 1'b0; // RULE8
               w.con = 1'b0; // RULE9
               w.busy = 1'b0;
               w.flt = 1'b0;
               w.code = cmd.wdata[7:0];
               w.pol = cmd.wdata[DAC_POL_BIT];
               w.rpt = cmd.wdata[DAC_RPT_BIT];
            end
            else if (!s_q.dac[ch_sel].en)
            begin
               // enable edge: the written connect bit picks the mode
               w.en = 1'b1;
               w.pol = cmd.wdata[DAC_POL_BIT]; // RULE10
               w.rpt = cmd.wdata[DAC_RPT_BIT];
               if (cmd.wdata[DAC_CON_BIT]) // RULE16
               begin
                  w.con = 1'b1; // RULE8
                  w.code = cmd.wdata[7:0];
               end
               else
               begin
                  w.con = 1'b0; // RULE7
                  w.busy = 1'b1;
                  w.code = DAC_MIDSCALE; // RULE12
               end
            end
            else if (!s_q.dac[ch_sel].busy && !s_q.dac[ch_sel].flt)
            begin
               // already enabled: connect bit stays device-owned
               w.rpt = cmd.wdata[DAC_RPT_BIT]; // RULE16
               // servo owns the code while it runs
               if (s_q.dac[ch_sel].con && !s_q.servo_en[ch_sel])
               begin
                  w.code = cmd.wdata[7:0];
                  w.pol = cmd.wdata[DAC_POL_BIT];
               end
            end
            s_d.dac[ch_sel] = w;
         end
      end

      // undervoltage compare on every new result
      if (adc.valid && adc.sel < 3'(NUM_INPUTS))
         s_d.uv_flt[adc.sel] = uv_trip(res, s_q.uv_lim[adc.sel]); // RULE1 RULE3

      // voltage servo, one step per new result of the servoed channel
      for (int c = 0; c < 2; c++)
      begin
         if (adc.valid && adc.sel == (c == 0 ? ADC_SEL_CHAN0 : ADC_SEL_CHAN1)
            && s_d.servo_en[c] && s_d.dac[c].con && !s_d.dac[c].busy)
         begin
            // target and count are taken after a same-cycle write, so a write starts over
            if (res == s_d.tgt[c])
            begin
               // stable means two equal results in a row
               if (!s_d.dac[c].rpt && s_d.last_ok[c] && s_d.last[c] == res) // RULE11
                  s_d.servo_en[c] = 1'b0;
            end
            else
               s_d.dac[c].code = step_code(s_d.dac[c].code,
                  servo_up(s_d.tgt[c], res, s_d.dac[c].pol)); // RULE4 RULE10 RULE15
            s_d.last[c] = res;
            s_d.last_ok[c] = 1'b1;
         end
      end

      // soft connect engine, one shared comparator walk
      sel_ch = {s_d.dac[1].busy, s_d.dac[0].busy};
      unique case (s_q.sc)
         SMC_SC_IDLE:
         begin
            if (sel_ch != 2'b00)
            begin
               cur = !sel_ch[0]; // RULE14
               s_d.sc_ch = cur;
               // no capture yet: the synchronised pin still lags the midscale load
               s_d.sc_prime = 1'b1;
               s_d.sc = SMC_SC_STEP;
            end
         end
         SMC_SC_STEP:
         begin
            cur = s_q.sc_ch;
            if (!s_d.dac[cur].busy)
               s_d.sc = SMC_SC_IDLE;
            else if (tick && s_q.sc_prime)
            begin
               // midscale has settled through the synchroniser by now, so the
               // captured sense belongs to the walk's own start point
               s_d.sc_prime = 1'b0;
               s_d.sc_cmp0 = s_q.cmp_s2[cur];
               s_d.dac[cur].code = step_code(s_q.dac[cur].code,
                  walk_up(s_q.cmp_s2[cur], s_q.dac[cur].pol)); // RULE7
            end
            else if (tick)
            begin
               if (s_q.cmp_s2[cur] != s_q.sc_cmp0)
               begin
                  // comparator flipped: dac pin now matches the output pin
                  s_d.dac[cur].con = 1'b1; // RULE7 RULE9
                  s_d.dac[cur].busy = 1'b0;
                  s_d.sc = SMC_SC_IDLE;
               end
               else if (s_q.dac[cur].code == DAC_CODE_MIN
                  || s_q.dac[cur].code == DAC_CODE_MAX)
               begin
                  s_d.dac[cur].flt = 1'b1; // RULE13
                  s_d.dac[cur].busy = 1'b0;
                  s_d.sc = SMC_SC_IDLE;
               end
               else
                  // single LSB toward the output pin
                  s_d.dac[cur].code = step_code(s_q.dac[cur].code,
                     walk_up(s_q.sc_cmp0, s_q.dac[cur].pol)); // RULE7 RULE10
            end
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_q.rdata <= 16'h0000;
         s_q.uv_lim <= {NUM_INPUTS{LIMIT_RESET}};
         s_q.uv_flt <= '0;
         s_q.tgt <= {2{LIMIT_RESET}};
         s_q.servo_en <= 2'b00; // RULE5
         s_q.dac <= {2{DAC_CODE_RESET, 6'b000000}}; // RULE9
         s_q.last <= {2{LIMIT_RESET}};
         s_q.last_ok <= 2'b00;
         s_q.sc <= SMC_SC_IDLE;
         s_q.sc_ch <= 1'b0;
         s_q.sc_cmp0 <= 1'b0;
         s_q.sc_prime <= 1'b0;
         s_q.div <= 8'h00;
         s_q.cmp_s1 <= 2'b00;
         s_q.cmp_s2 <= 2'b00;
      end
      else
         s_q <= s_d;
   end

   // ==========================================================
   // outputs
   assign cmd_rdata = s_q.rdata;
   assign uv_fault = s_q.uv_flt;
   // attach needs both bits, so clearing enable detaches in the same cycle
   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         dac_code[c] = s_q.dac[c].code;
         margin_output_en[c] = s_q.dac[c].en; // RULE8
         buffer_attach[c] = s_q.dac[c].en && s_q.dac[c].con; // RULE8
         dac_fault[c] = s_q.dac[c].flt; // RULE13
      end
   end

endmodule

`default_nettype wire

// ===== test/smc_props.sv
// port assertions for the channel control block
`timescale 1ns/10ps
`default_nettype none
module smc_props
   import smc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // register and conversion ports
   input wire smc_cmd_t cmd,
   input wire logic [15:0] cmd_rdata,
   input wire smc_adc_t adc,
   // outputs
   input wire logic [1:0][7:0] dac_code,
   input wire logic [1:0] margin_output_en,
   input wire logic [1:0] buffer_attach,
   input wire logic [1:0] dac_fault,
   input wire logic [NUM_INPUTS-1:0] uv_fault
);
   // ==========================================================
   // properties
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   logic wr0;
   assign wr0 = cmd.wr_en && cmd.idx == 4'h8;
   property p_uv_hold;
      !adc.valid |=> $stable(uv_fault);
   endproperty
   a_uv_hold: assert property (p_uv_hold) else $error("uv moved");
   property p_hard;
      wr0 && cmd.wdata[9:8] == 2'b11 && !margin_output_en[0] && !dac_fault[0]
         |=> buffer_attach[0] && dac_code[0] == $past(cmd.wdata[7:0]);
   endproperty
   a_hard: assert property (p_hard) else $error("hard connect");
   property p_off;
      wr0 && !cmd.wdata[8] |=> !margin_output_en[0] && !buffer_attach[0];
   endproperty
   a_off: assert property (p_off) else $error("not tri-stated");
   property p_soft_start;
      wr0 && cmd.wdata[9:8] == 2'b01 && !margin_output_en[0] && !dac_fault[0]
         |=> dac_code[0] == 8'h80 && margin_output_en[0] && !buffer_attach[0];
   endproperty
   a_soft_start: assert property (p_soft_start) else $error("soft start");
   // wrap from FF to 00 slips through, traded for a short check
   property p_step1;
      margin_output_en[0] && !cmd.wr_en |=> dac_code[0] == $past(dac_code[0])
         || dac_code[0] == $past(dac_code[0]) + 8'h01
         || dac_code[0] == $past(dac_code[0]) - 8'h01;
   endproperty
   a_step1: assert property (p_step1) else $error("step too big");
   property p_soft_pace;
      $changed(dac_code[0]) && margin_output_en[0] && !buffer_attach[0]
         |=> $stable(dac_code[0]) [*8];
   endproperty
   a_soft_pace: assert property (p_soft_pace) else $error("soft pace");
   property p_fault_open;
      $rose(dac_fault[0]) |-> !buffer_attach[0] && dac_code[0] inside {8'h00, 8'hFF};
   endproperty
   a_fault_open: assert property (p_fault_open) else $error("bad fault");
   property p_con_read;
      $past(cmd.rd_en) && $past(cmd.idx) == 4'h8
         |-> cmd_rdata[9:8] == {$past(buffer_attach[0]), $past(margin_output_en[0])};
   endproperty
   a_con_read: assert property (p_con_read) else $error("con read");
   property p_rsv_read;
      $past(cmd.rd_en) && $past(cmd.idx[3:1]) == 3'h4 |-> cmd_rdata[15:12] == 4'h0;
   endproperty
   a_rsv_read: assert property (p_rsv_read) else $error("reserved read");
endmodule
bind smc_channel_ctrl smc_props smc_props_i (.core_clk, .reset_n, .cmd, .cmd_rdata,
   .adc, .dac_code, .margin_output_en, .buffer_attach, .dac_fault, .uv_fault);
`default_nettype wire

// ===== test/smc_fb_model.sv
// far-side model: feedback node seen by the soft connect comparators
`timescale 1ns/10ps
`default_nettype none
module smc_fb_model
#(
   parameter logic [7:0] THR0 = 8'h90,
   parameter logic [7:0] THR1 = 8'h83
)
(
   // codes from the block
   input wire logic [1:0][7:0] dac_code,
   // comparators, high while the dac pin sits below the output pin
   output logic [1:0] soft_cmp
);
   // output pin level fixed per channel, dac pin rises with its code
   assign soft_cmp[0] = dac_code[0] < THR0;
   assign soft_cmp[1] = dac_code[1] < THR1;
endmodule
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench for the channel control block
`timescale 1ns/10ps
`default_nettype none
module testbench
   import smc_pkg::*;
;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   smc_cmd_t cmd = '0;
   smc_adc_t adc = '0;
   logic [15:0] cmd_rdata;
   logic [1:0][7:0] dac_code;
   logic [1:0] soft_cmp, margin_output_en, buffer_attach, dac_fault;
   logic [NUM_INPUTS-1:0] uv_fault;
   logic [15:0] q[$];
   logic rd_d = 1'b0;
   logic [31:0] rs = 32'hDB32;
   logic [14:0] lim, r;
   int err_total = 0;
   int n_tests = 0;
   int n;
   always #25 core_clk = ~core_clk;
   smc_channel_ctrl smc_channel_ctrl_i (.core_clk, .reset_n, .cmd, .cmd_rdata, .adc,
      .soft_cmp, .dac_code, .margin_output_en, .buffer_attach, .dac_fault, .uv_fault);
   smc_fb_model smc_fb_model_i (.dac_code, .soft_cmp);
   // ==========================================================
   // helpers
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tmo(input int k);
      if (k >= 30000)
      begin
         err_total++;
         stop_test;
      end
   endtask
   task automatic wr(input logic [3:0] i, input logic [15:0] d);
      cmd.idx = i;
      cmd.wdata = d;
      cmd.wr_en = 1'b1;
      @(negedge core_clk);
      cmd.wr_en = 1'b0;
      @(negedge core_clk);
   endtask
   // expected read data waits in the queue for the monitor
   task automatic rd(input logic [3:0] i, input logic [15:0] e);
      q.push_back(e);
      cmd.idx = i;
      cmd.rd_en = 1'b1;
      @(negedge core_clk);
      cmd.rd_en = 1'b0;
      @(negedge core_clk);
   endtask
   task automatic ad(input logic [2:0] s, input logic [14:0] v);
      adc.sel = s;
      adc.result = v;
      adc.valid = 1'b1;
      @(negedge core_clk);
      adc.valid = 1'b0;
      @(negedge core_clk);
   endtask
   always @(posedge core_clk) rd_d <= cmd.rd_en;
   always @(negedge core_clk)
      if (rd_d)
         chk(cmd_rdata, q.pop_front());
   // ==========================================================
   // scenarios
   initial
   begin
      repeat (8) @(negedge core_clk);
      reset_n = 1'b1;
      @(negedge core_clk);
      rd(4'h8, 16'h0000);
      rd(4'h6, 16'h0000);
      rd(4'hF, 16'h0000);
      $display("test reset done");
      for (int i = 0; i < 6; i++)
      begin
         rs = nx(rs);
         lim = rs[14:0];
         rs = nx(rs);
         r = rs[14:0];
         wr(i[3:0], {1'b1, lim});
         rd(i[3:0], {1'b0, lim});
         ad(i[2:0], r);
         chk(uv_fault[i], lim != 15'h4000 && $signed(r) > $signed(lim));
         ad(i[2:0], lim);
         chk(uv_fault[i], 1'b0);
         wr(i[3:0], 16'h4000);
         ad(i[2:0], 15'h3FFF);
         chk(uv_fault[i], 1'b0);
      end
      $display("test limits done");
      wr(4'h8, 16'hF710);
      rd(4'h8, 16'h0710);
      chk({margin_output_en[0], buffer_attach[0], dac_code[0]}, {2'b11, 8'h10});
      wr(4'h6, 16'h8100);
      rd(4'h6, 16'h8100);
      ad(3'h2, 15'h0050);
      chk(dac_code[0], 8'h11);
      ad(3'h2, 15'h0050);
      chk(dac_code[0], 8'h12);
      ad(3'h2, 15'h0200);
      chk(dac_code[0], 8'h11);
      ad(3'h4, 15'h0050);
      chk(dac_code[0], 8'h11);
      ad(3'h2, 15'h0100);
      ad(3'h2, 15'h0100);
      @(negedge core_clk);
      rd(4'h6, 16'h0100);
      ad(3'h2, 15'h0050);
      chk(dac_code[0], 8'h11);
      wr(4'h8, 16'h0F11);
      wr(4'h6, 16'h8100);
      ad(3'h2, 15'h0100);
      ad(3'h2, 15'h0100);
      ad(3'h2, 15'h0050);
      chk(dac_code[0], 8'h12);
      wr(4'h8, 16'h0D55);
      rd(4'h8, 16'h0F12);
      wr(4'h6, 16'h0000);
      wr(4'h8, 16'h0000);
      chk({margin_output_en[0], buffer_attach[0]}, 2'b00);
      $display("test servo done");
      wr(4'h8, 16'h0133);
      wr(4'h9, 16'h0544);
      chk(dac_code, 16'h8080);
      repeat (1000) @(negedge core_clk);
      chk(dac_code[1], 8'h80);
      chk(dac_code[0] < 8'h80, 1'b1);
      for (n = 0; n < 30000 && dac_fault[0] !== 1'b1; n++) @(negedge core_clk);
      tmo(n);
      chk({dac_fault[0], buffer_attach[0], dac_code[0]}, {2'b10, 8'h00});
      wr(4'h8, 16'h0380);
      rd(4'h8, 16'h0100);
      for (n = 0; n < 30000 && buffer_attach[1] !== 1'b1; n++) @(negedge core_clk);
      tmo(n);
      rd(4'h9, 16'h0783);
      wr(4'h8, 16'h0000);
      chk(dac_fault[0], 1'b0);
      $display("test soft connect done");
      stop_test;
   end
endmodule
`default_nettype wire
